/* hw/action_spec_and_irq_vector.sv */
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// - Fetch the action word once per serial or local-bus action request.
// - Full setup reads all slot assignments plus selected channel spec.
// - Channel reconfigure reads only the selected channel spec.
// - Global reinit loads slots and all channel specs, reinit every slot.
// - Queue attention adopts new queues and zeros each write counter whose queue is not written that cycle.
// - Decode loop bits into six codes; 100 and 111 are illegal.
// - Complete external loop returns serial input straight to output.
// - Complete internal loop feeds output back, ignoring external input.
// - Channelwise external loop copies one channel receive to transmit.
// - Channelwise internal loop returns one channel transmit into receive.
// - Local-bus word honours only reconfigure, queue attention, channel A/B.
// - Channel event writes interrupt word into queue and pulses interrupt.
// - Coinciding events of one channel and direction merge into one word.
// - Separate receive and transmit queues, each from its own base.
// - Word has bit 29 set, direction bit 28, flags, channel in 4:0.
// - Direction bit is one for receive, zero for transmit.
// - Flags unused by the channel mode are forced to zero.
// - Receive-only flags need receive; transmit-only flags need transmit.
// - Late-halt only on transmit, HDLC, terminal bus, grant during send.
module action_spec_and_irq_vector
    import action_pkg::*;
#(
    parameter int QUEUE_AW = 32,
    parameter int QUEUE_WORDS = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    // Action requests and word fetch from shared memory
    input wire logic serial_core_action_req,
    input wire logic lb_action_req,
    output logic fetch_req,
    output logic fetch_lb,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_data,
    // Decoded actions: one-cycle pulses and held channel fields
    output logic full_setup_go,
    output logic reconfig_go,
    output logic reinit_go,
    output logic lb_reconfig_go,
    output logic [4:0] action_channel,
    output logic lb_channel_b,
    output logic loop_illegal,
    // Loop control
    output logic [2:0] loop_kind,
    output logic [4:0] loop_channel,
    input wire logic ser_in_pin,
    output logic ser_out_pin,
    input wire logic core_tx_bit,
    output logic core_rx_bit,
    input wire logic [4:0] active_slot_channel,
    // Channel events
    input wire logic [4:0] ev_channel,
    input wire logic ev_rx,
    input wire logic ev_tx,
    input wire logic [1:0] ev_mode,
    input wire logic [18:0] ev_flags,
    input wire logic term_bus_mode,
    input wire logic d_channel_grant,
    // Queue write toward host memory
    input wire logic [QUEUE_AW-1:0] rx_queue_base,
    input wire logic [QUEUE_AW-1:0] tx_queue_base,
    output logic qwr_valid,
    output logic [QUEUE_AW-1:0] qwr_addr,
    output logic [31:0] qwr_data,
    output logic irq_pulse
);
    // Elaboration checks: the 8-bit queue counters and the 10-bit word offset set the limits
    if (QUEUE_WORDS < 2 || QUEUE_WORDS > 256) begin : g_words_check
        $error("QUEUE_WORDS out of range");
    end
    if (QUEUE_AW < 10) begin : g_aw_check
        $error("QUEUE_AW too small");
    end

    typedef struct packed {
        logic fetch_pend;
        logic fetch_lb;
        logic full_setup;
        logic reconfig;
        logic reinit;
        logic lb_reconfig;
        logic [4:0] act_ch;
        logic lb_b;
        logic illegal;
        logic [2:0] loop_k;
        logic [4:0] loop_ch;
        logic [7:0] rx_cnt;
        logic [7:0] tx_cnt;
        logic [7:0] lb_cnt;
        logic tx_hold;
        logic [4:0] tx_hold_ch;
        logic [1:0] tx_hold_mode;
        logic [18:0] tx_hold_flags;
        logic tx_hold_late;
        logic q_valid;
        logic [QUEUE_AW-1:0] q_addr;
        logic [31:0] q_data;
        logic ser_out;
        logic core_rx;
        logic [2:0] pin_sync;
        logic pin_lvl;
        logic ser_wait;
        logic lb_wait;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic rst_meta_r;
    logic rst_sync_n_r;
    logic pin_level;
    logic [31:0] rx_word;
    logic [31:0] tx_word;
    logic [2:0] code;
    logic ser_any;
    logic lb_any;

    // Reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // Build an interrupt word, masking flags the mode or direction forbids
    function automatic logic [31:0] make_word(input logic [4:0] ch, input logic rx,
                                              input logic [1:0] mode,
                                              input logic [18:0] fl, input logic late);
        logic [18:0] m;
        logic [31:0] w;
        // Flag order: 18 framing change, 17..11 frame E bits, 10 status b, 9 status a,
        // 8 X, 7 host, 6 frame end, 5 idle change, 4 short, 3 fault, 2 overflow,
        // 1 tx done, 0 late halt; flag k lands in word bit k+5
        m = 19'h0;
        m[7] = 1'b1;
        m[3] = 1'b1;
        m[2] = 1'b1;
        case (mode)
            MODE_HDLC: begin
                m[6] = 1'b1;
                m[5] = rx;
                m[4] = rx;
                m[1] = !rx;
            end
            MODE_RATE: begin
                m[18:8] = {11{rx}};
            end
            MODE_TMA: begin
                m[6] = !rx;
                m[1] = !rx;
            end
            default: begin
                m[6] = 1'b1;
                m[1] = !rx;
            end
        endcase
        w = 32'h0;
        w[IV_MARK +: 2] = IV_MARK_VAL;
        w[IV_DIR] = rx;
        w[23:5] = fl & m;
        // Late halt only for HDLC transmit on the terminal bus
        w[5] = late && !rx && (mode == MODE_HDLC);
        w[4:0] = ch;
        return w;
    endfunction : make_word

    // Pin level moves only once the last two stages agree; a disagreement keeps
    // the last agreed level rather than borrowing any other signal
    assign pin_level = (st_r.pin_sync[1] == st_r.pin_sync[2]) ? st_r.pin_sync[1] : st_r.pin_lvl;
    // A request that meets a busy fetch port waits its turn instead of being lost
    assign ser_any = st_r.ser_wait || serial_core_action_req;
    assign lb_any = st_r.lb_wait || lb_action_req;
    // Loop code of the arriving word and the two candidate interrupt words
    assign code = {fetch_data[POS_PER_CHAN], fetch_data[POS_OUTWARD], fetch_data[POS_INWARD]};
    assign rx_word = make_word(ev_channel, 1'b1, ev_mode, ev_flags, 1'b0);
    assign tx_word = make_word(ev_channel, 1'b0, ev_mode, ev_flags,
                               term_bus_mode && d_channel_grant && ev_flags[0]);

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.full_setup = 1'b0;
        st_nxt.reconfig = 1'b0;
        st_nxt.reinit = 1'b0;
        st_nxt.lb_reconfig = 1'b0;
        st_nxt.illegal = 1'b0;
        st_nxt.q_valid = 1'b0;
        st_nxt.pin_sync = {st_r.pin_sync[1:0], ser_in_pin};
        st_nxt.pin_lvl = pin_level;
        // Requests stay noted until their own fetch starts
        st_nxt.ser_wait = ser_any;
        st_nxt.lb_wait = lb_any;

        // One fetch per request; a new request waits until the last one lands
        if (!st_r.fetch_pend && (ser_any || lb_any)) begin
            st_nxt.fetch_pend = 1'b1;
            st_nxt.fetch_lb = !ser_any;
            // Serial core goes first; a local-bus request keeps waiting its turn
            if (ser_any) begin
                st_nxt.ser_wait = 1'b0;
            end else begin
                st_nxt.lb_wait = 1'b0;
            end
        end else if (st_r.fetch_pend && fetch_valid) begin
            st_nxt.fetch_pend = 1'b0;
            if (st_r.fetch_lb) begin
                // Local-bus word: only reconfigure, queue attention, A/B
                st_nxt.lb_reconfig = fetch_data[POS_RECONFIG];
                st_nxt.lb_b = fetch_data[POS_LB_CHAN];
                // Local-bus attention only restarts its count; no local-bus words are written here
                if (fetch_data[POS_QUEUE_ATT]) begin
                    st_nxt.lb_cnt = 8'h0;
                end
            end else begin
                st_nxt.act_ch = fetch_data[POS_CHAN_LO +: 5];
                // Requests are exclusive by software; priority is a safe tiebreak
                st_nxt.full_setup = fetch_data[POS_FULL_SETUP];
                st_nxt.reconfig = fetch_data[POS_RECONFIG] &&
                                  !fetch_data[POS_FULL_SETUP];
                st_nxt.reinit = fetch_data[POS_REINIT] &&
                                !fetch_data[POS_FULL_SETUP] &&
                                !fetch_data[POS_RECONFIG];
                // Host has defined new queues: each count restarts at the base unless its queue is written this cycle
                if (fetch_data[POS_QUEUE_ATT]) begin
                    st_nxt.rx_cnt = 8'h0;
                    st_nxt.tx_cnt = 8'h0;
                end
                // Loop decode; loops off clears the mirror, no loop keeps it
                case (code)
                    LOOP_NONE: st_nxt.loop_k = st_r.loop_k;
                    LOOP_INT_ALL: st_nxt.loop_k = LK_INT_ALL;
                    LOOP_EXT_ALL: st_nxt.loop_k = LK_EXT_ALL;
                    LOOP_OFF: st_nxt.loop_k = LK_NONE;
                    LOOP_INT_CH: st_nxt.loop_k = LK_INT_CH;
                    LOOP_EXT_CH: st_nxt.loop_k = LK_EXT_CH;
                    default: st_nxt.illegal = 1'b1;
                endcase
                if (code != LOOP_NONE && code != 3'h4 && code != 3'h7) begin
                    st_nxt.loop_ch = fetch_data[POS_CHAN_LO +: 5];
                end
            end
        end

        // Serial data path under loop control
        case (st_r.loop_k)
            LK_EXT_ALL: begin
                st_nxt.ser_out = pin_level;
                st_nxt.core_rx = pin_level;
            end
            LK_INT_ALL: begin
                st_nxt.ser_out = core_tx_bit;
                st_nxt.core_rx = core_tx_bit;
            end
            LK_EXT_CH: begin
                // Looped channel echoes its received bit
                st_nxt.ser_out = (active_slot_channel == st_r.loop_ch) ? pin_level : core_tx_bit;
                st_nxt.core_rx = pin_level;
            end
            LK_INT_CH: begin
                st_nxt.ser_out = core_tx_bit;
                // Looped channel receives its own transmit
                st_nxt.core_rx = (active_slot_channel == st_r.loop_ch) ? core_tx_bit : pin_level;
            end
            default: begin
                st_nxt.ser_out = core_tx_bit;
                st_nxt.core_rx = pin_level;
            end
        endcase

        // Queue writes: receive first, a coinciding transmit word held until a cycle with no receive event.
        // Limitation: only one transmit word can wait, so the source must not
        // present transmit events on back-to-back receive cycles.
        if (ev_rx) begin
            st_nxt.q_valid = 1'b1;
            st_nxt.q_addr = rx_queue_base +
                            QUEUE_AW'({st_r.rx_cnt, 2'b00});
            st_nxt.q_data = rx_word;
            st_nxt.rx_cnt = (st_r.rx_cnt == 8'(QUEUE_WORDS - 1)) ? 8'h0 : st_r.rx_cnt + 8'h1;
            if (st_r.tx_hold) begin
                st_nxt.tx_hold = 1'b1;
            end else if (ev_tx) begin
                st_nxt.tx_hold = 1'b1;
                st_nxt.tx_hold_ch = ev_channel;
                st_nxt.tx_hold_mode = ev_mode;
                st_nxt.tx_hold_flags = ev_flags;
                st_nxt.tx_hold_late = term_bus_mode && d_channel_grant && ev_flags[0];
            end
        end else if (st_r.tx_hold || ev_tx) begin
            st_nxt.q_valid = 1'b1;
            st_nxt.q_addr = tx_queue_base + QUEUE_AW'({st_r.tx_cnt, 2'b00});
            st_nxt.q_data = st_r.tx_hold ?
                make_word(st_r.tx_hold_ch, 1'b0, st_r.tx_hold_mode, st_r.tx_hold_flags,
                          st_r.tx_hold_late) : tx_word;
            st_nxt.tx_cnt = (st_r.tx_cnt == 8'(QUEUE_WORDS - 1)) ? 8'h0 : st_r.tx_cnt + 8'h1;
            st_nxt.tx_hold = st_r.tx_hold && ev_tx;
            if (st_r.tx_hold && ev_tx) begin
                st_nxt.tx_hold_ch = ev_channel;
                st_nxt.tx_hold_mode = ev_mode;
                st_nxt.tx_hold_flags = ev_flags;
                st_nxt.tx_hold_late = term_bus_mode && d_channel_grant && ev_flags[0];
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fetch_req = st_r.fetch_pend;
    assign fetch_lb = st_r.fetch_lb;
    assign full_setup_go = st_r.full_setup;
    assign reconfig_go = st_r.reconfig;
    assign reinit_go = st_r.reinit;
    assign lb_reconfig_go = st_r.lb_reconfig;
    assign action_channel = st_r.act_ch;
    assign lb_channel_b = st_r.lb_b;
    assign loop_illegal = st_r.illegal;
    assign loop_kind = st_r.loop_k;
    assign loop_channel = st_r.loop_ch;
    assign ser_out_pin = st_r.ser_out;
    assign core_rx_bit = st_r.core_rx;
    assign qwr_valid = st_r.q_valid;
    assign qwr_addr = st_r.q_addr;
    assign qwr_data = st_r.q_data;
    assign irq_pulse = st_r.q_valid;
endmodule : action_spec_and_irq_vector

/* shared/action_pkg.sv */
package action_pkg;
    // Action word field positions (serial core and local bus)
    localparam int POS_FULL_SETUP = 15;
    localparam int POS_RECONFIG = 14;
    localparam int POS_CHAN_LO = 8;
    localparam int POS_REINIT = 6;
    localparam int POS_PER_CHAN = 5;
    localparam int POS_OUTWARD = 4;
    localparam int POS_INWARD = 3;
    localparam int POS_QUEUE_ATT = 2;
    localparam int POS_LB_CHAN = 8;
    // Interrupt word layout
    localparam int IV_MARK = 29;
    localparam int IV_DIR = 28;
    localparam logic [1:0] IV_MARK_VAL = 2'h1;
    // Loop codes {per_channel, outward, inward}
    localparam logic [2:0] LOOP_NONE = 3'h0;
    localparam logic [2:0] LOOP_INT_ALL = 3'h1;
    localparam logic [2:0] LOOP_EXT_ALL = 3'h2;
    localparam logic [2:0] LOOP_OFF = 3'h3;
    localparam logic [2:0] LOOP_INT_CH = 3'h5;
    localparam logic [2:0] LOOP_EXT_CH = 3'h6;
    // Protocol modes of a channel
    localparam logic [1:0] MODE_HDLC = 2'h0;
    localparam logic [1:0] MODE_RATE = 2'h1;
    localparam logic [1:0] MODE_TMA = 2'h2;
    localparam logic [1:0] MODE_TMB = 2'h3;
    // Loop state kinds
    typedef enum logic [2:0] {
        LK_NONE = 3'b000,
        LK_INT_ALL = 3'b001,
        LK_EXT_ALL = 3'b010,
        LK_INT_CH = 3'b101,
        LK_EXT_CH = 3'b110
    } loop_e;
endpackage : action_pkg

/* tb/action_properties.sv */
`timescale 1ns/100ps
module action_checker
    import action_pkg::*;
#(
    parameter int QUEUE_AW = 32,
    parameter int QUEUE_WORDS = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic serial_core_action_req,
    input wire logic fetch_req,
    input wire logic fetch_lb,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_data,
    input wire logic full_setup_go,
    input wire logic reconfig_go,
    input wire logic reinit_go,
    input wire logic lb_reconfig_go,
    input wire logic [4:0] action_channel,
    input wire logic lb_channel_b,
    input wire logic loop_illegal,
    input wire logic [2:0] loop_kind,
    input wire logic [4:0] ev_channel,
    input wire logic ev_rx,
    input wire logic ev_tx,
    input wire logic [31:0] qwr_data,
    input wire logic irq_pulse
);
    logic sv;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Serial-core word arriving from memory
    assign sv = fetch_req && fetch_valid && !fetch_lb;
    AST_FETCH_TAKEN: assert property (serial_core_action_req && !fetch_req |=> fetch_req)
        else $error("action request not fetched");
    AST_FETCH_HOLD: assert property (fetch_req && !fetch_valid |=> fetch_req)
        else $error("fetch dropped before word arrived");
    AST_FULL_GO: assert property (sv && fetch_data[POS_FULL_SETUP] |=> full_setup_go
        && !reconfig_go && action_channel == $past(fetch_data[12:8])) else $error("full setup");
    AST_RECONF_GO: assert property (sv && fetch_data[15:14] == 2'h1 |=> reconfig_go
        && !full_setup_go && !reinit_go) else $error("reconfigure");
    AST_REINIT_GO: assert property (sv && fetch_data[15:14] == 2'h0 && fetch_data[POS_REINIT]
        |=> reinit_go && !reconfig_go) else $error("global reinit");
    AST_LOOP_BAD: assert property (sv && fetch_data[5:3] inside {3'h4, 3'h7}
        |=> loop_illegal && $stable(loop_kind)) else $error("illegal loop code");
    AST_LB_WORD: assert property (fetch_valid && fetch_lb && fetch_data[POS_RECONFIG]
        |=> lb_reconfig_go && !full_setup_go && lb_channel_b == $past(fetch_data[8]))
        else $error("local bus word");
    AST_RX_WORD: assert property (ev_rx |=> irq_pulse && qwr_data[31:28] == 4'h3
        && qwr_data[4:0] == $past(ev_channel)) else $error("receive word");
    AST_TX_WORD: assert property (ev_tx && !ev_rx |=> irq_pulse && qwr_data[31:28] == 4'h2)
        else $error("transmit word");
    AST_RX_NO_TX_FLAGS: assert property (ev_rx |=> qwr_data[6:5] == 2'h0)
        else $error("transmit-only flag in receive word");
    // Main scenarios reached
    cover property (full_setup_go);
    cover property (loop_kind == LOOP_EXT_CH);
    cover property (ev_rx && ev_tx);
endmodule : action_checker

bind action_spec_and_irq_vector action_checker #(
    .QUEUE_AW(QUEUE_AW), .QUEUE_WORDS(QUEUE_WORDS)
) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .serial_core_action_req(serial_core_action_req),
    .fetch_req(fetch_req), .fetch_lb(fetch_lb), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .full_setup_go(full_setup_go), .reconfig_go(reconfig_go),
    .reinit_go(reinit_go), .lb_reconfig_go(lb_reconfig_go), .action_channel(action_channel),
    .lb_channel_b(lb_channel_b), .loop_illegal(loop_illegal), .loop_kind(loop_kind),
    .ev_channel(ev_channel), .ev_rx(ev_rx), .ev_tx(ev_tx), .qwr_data(qwr_data),
    .irq_pulse(irq_pulse)
);

/* tb/host_mem_model.sv */
`timescale 1ns/100ps
module host_mem_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic fetch_req,
    input wire logic fetch_lb,
    input wire logic [3:0] delay,
    input wire logic [31:0] core_word,
    input wire logic [31:0] lb_word,
    output logic fetch_valid,
    output logic [31:0] fetch_data
);
    logic [3:0] wait_r;
    // One word per fetch after a chosen delay; data scrambled outside the valid cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fetch_valid <= 1'b0;
            fetch_data <= 32'h0;
            wait_r <= 4'h0;
        end else if (fetch_valid) begin
            fetch_valid <= 1'b0;
            fetch_data <= ~fetch_data;
        end else if (fetch_req && wait_r == delay) begin
            fetch_valid <= 1'b1;
            fetch_data <= fetch_lb ? lb_word : core_word;
            wait_r <= 4'h0;
        end else if (fetch_req) begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule : host_mem_model

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench
    import action_pkg::*;
;
    localparam int QW = 4;
    logic ref_clk, resetn, serial_core_action_req, lb_action_req, fetch_valid, ser_in_pin;
    logic core_tx_bit, ev_rx, ev_tx, term_bus_mode, d_channel_grant, fetch_req, fetch_lb;
    logic full_setup_go, reconfig_go, reinit_go, lb_reconfig_go, lb_channel_b, loop_illegal;
    logic ser_out_pin, core_rx_bit, qwr_valid, irq_pulse;
    logic [31:0] fetch_data, qwr_data, qwr_addr, rx_queue_base, tx_queue_base, core_word, lb_word;
    logic [4:0] action_channel, loop_channel, active_slot_channel, ev_channel;
    logic [2:0] loop_kind;
    logic [1:0] ev_mode;
    logic [18:0] ev_flags;
    logic [3:0] delay;
    int n_errors = 0, n_checks = 0, cyc = 0, rxc = 0, txc = 0;
    logic [2:0] code[14] = '{3'h5, 3'h3, 3'h0, 3'h6, 3'h3, 3'h0, 3'h1, 3'h3, 3'h0, 3'h2, 3'h3, 3'h0,
        3'h4, 3'h7};
    logic [2:0] ek[14] = '{3'h5, 3'h0, 3'h0, 3'h6, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h2, 3'h0, 3'h0,
        3'h0, 3'h0};
    logic [31:0] erx[4] = '{32'h30001f80, 32'h30fff180, 32'h30001180, 32'h30001980};
    logic [31:0] etx[4] = '{32'h200019e0, 32'h20001180, 32'h200019c0, 32'h200019c0};

    action_spec_and_irq_vector #(.QUEUE_WORDS(QW)) DUT (
        .ref_clk(ref_clk), .resetn(resetn), .serial_core_action_req(serial_core_action_req),
        .lb_action_req(lb_action_req), .fetch_req(fetch_req), .fetch_lb(fetch_lb),
        .fetch_valid(fetch_valid), .fetch_data(fetch_data), .full_setup_go(full_setup_go),
        .reconfig_go(reconfig_go), .reinit_go(reinit_go), .lb_reconfig_go(lb_reconfig_go),
        .action_channel(action_channel), .lb_channel_b(lb_channel_b),
        .loop_illegal(loop_illegal), .loop_kind(loop_kind), .loop_channel(loop_channel),
        .ser_in_pin(ser_in_pin), .ser_out_pin(ser_out_pin), .core_tx_bit(core_tx_bit),
        .core_rx_bit(core_rx_bit), .active_slot_channel(active_slot_channel),
        .ev_channel(ev_channel), .ev_rx(ev_rx), .ev_tx(ev_tx), .ev_mode(ev_mode),
        .ev_flags(ev_flags), .term_bus_mode(term_bus_mode), .d_channel_grant(d_channel_grant),
        .rx_queue_base(rx_queue_base), .tx_queue_base(tx_queue_base), .qwr_valid(qwr_valid),
        .qwr_addr(qwr_addr), .qwr_data(qwr_data), .irq_pulse(irq_pulse));

    host_mem_model mem (
        .ref_clk(ref_clk), .resetn(resetn), .fetch_req(fetch_req), .fetch_lb(fetch_lb),
        .delay(delay), .core_word(core_word), .lb_word(lb_word), .fetch_valid(fetch_valid),
        .fetch_data(fetch_data));

    // Clock and a cycle ceiling well above the fewer than 200 cycles the tests need
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            $display("BAD at %0t: timeout", $time);
            end_of_test();
        end
    end

    task chk(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Place a word in memory, request it, return just after the decode edge
    task act(input logic lb, input logic [31:0] w);
        int i;
        @(posedge ref_clk);
        core_word <= w;
        lb_word <= w;
        serial_core_action_req <= !lb;
        lb_action_req <= lb;
        @(posedge ref_clk);
        serial_core_action_req <= 1'b0;
        lb_action_req <= 1'b0;
        for (i = 0; i < 40 && fetch_valid !== 1'b1; i++) @(posedge ref_clk);
        #1;
        chk({fetch_req, i < 40}, 2'h1);
    endtask : act

    // One event edge; a joint rx and tx event yields the rx word first
    task ev(input logic [1:0] m, input logic r, input logic t, input logic [31:0] er,
        input logic [31:0] et);
        @(posedge ref_clk);
        ev_mode <= m;
        ev_rx <= r;
        ev_tx <= t;
        @(posedge ref_clk);
        ev_rx <= 1'b0;
        ev_tx <= 1'b0;
        #1;
        if (r) begin
            chk({irq_pulse, qwr_valid, qwr_data}, {2'h3, er | 32'h0b});
            chk(qwr_addr, rx_queue_base + 32'(4 * rxc));
            rxc = (rxc + 1) % QW;
            if (t) begin
                @(posedge ref_clk);
                #1;
            end
        end
        if (t) begin
            chk({irq_pulse, qwr_valid, qwr_data}, {2'h3, et | 32'h0b});
            chk(qwr_addr, tx_queue_base + 32'(4 * txc));
            txc = (txc + 1) % QW;
        end
    endtask : ev

    // Hold pin high and core bit low, then see which one each loop routes
    task path(input logic [2:0] k);
        @(posedge ref_clk);
        ser_in_pin <= 1'b1;
        core_tx_bit <= 1'b0;
        active_slot_channel <= (k == LOOP_EXT_CH) ? 5'h02 : 5'h09;
        repeat (6) @(posedge ref_clk);
        #1;
        case (k)
            LOOP_INT_ALL: chk(core_rx_bit, 1'b0);
            LOOP_EXT_ALL: chk(ser_out_pin, 1'b1);
            LOOP_EXT_CH: chk(ser_out_pin, 1'b0);
            default: chk(core_rx_bit, 1'b0);
        endcase
    endtask : path

    task end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        int i;
        {ref_clk, resetn, serial_core_action_req, lb_action_req, ser_in_pin, core_tx_bit} = '0;
        {ev_rx, ev_tx, ev_mode, active_slot_channel, core_word, lb_word, delay} = '0;
        {term_bus_mode, d_channel_grant, ev_channel, ev_flags} = {2'h3, 5'h0b, 19'h7ffff};
        rx_queue_base = 32'h00001000;
        tx_queue_base = 32'h00002000;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        act(1'b0, 32'h00009300);
        chk({full_setup_go, reconfig_go, reinit_go, lb_reconfig_go, action_channel}, 9'h113);
        delay <= 4'h3;
        act(1'b0, 32'h00004700);
        chk({full_setup_go, reconfig_go, reinit_go, lb_reconfig_go, action_channel}, 9'h087);
        act(1'b0, 32'h00000040);
        chk({full_setup_go, reconfig_go, reinit_go, lb_reconfig_go}, 4'h2);
        act(1'b1, 32'h0000c104);
        chk({full_setup_go, reconfig_go, lb_reconfig_go, lb_channel_b}, 4'h3);
        delay <= 4'h0;
        // Close, switch off, then send no loop for each loop on channel 9, then the two bad codes
        for (i = 0; i < 14; i++) begin
            act(1'b0, {19'h0, 5'h09, 2'h0, code[i], 3'h0});
            chk({loop_kind, loop_illegal}, {ek[i], code[i] == 3'h4 || code[i] == 3'h7});
            if (ek[i] != 3'h0) begin
                chk(loop_channel, 5'h09);
                path(ek[i]);
            end
        end
        for (i = 0; i < 4; i++) ev(i[1:0], 1'b1, 1'b1, erx[i], etx[i]);
        d_channel_grant <= 1'b0;
        ev(MODE_HDLC, 1'b0, 1'b1, 32'h0, 32'h200019c0);
        // One receive word so the queue attention below has a receive count to clear
        ev(MODE_HDLC, 1'b1, 1'b0, erx[0], 32'h0);
        act(1'b0, 32'h00000004);
        rxc = 0;
        txc = 0;
        ev(MODE_HDLC, 1'b1, 1'b1, erx[0], 32'h200019c0);
        end_of_test();
    end
endmodule : testbench
